// [hw/cmd_decoder.sv]
`timescale 1ns/1ns
`include "pds_defines.svh"
module cmd_decoder
  import pds_pkg::*;
(
  input wire logic [15:0] cmdWord,
  input wire logic prevFaultReset,
  output cmd_decode_t dec
);
  logic so;
  logic ev;
  logic qs;
  logic eo;
  assign so = cmdWord[`CW_SWITCH_ON];
  assign ev = cmdWord[`CW_ENABLE_VOLTAGE];
  assign qs = cmdWord[`CW_QUICK_STOP];
  assign eo = cmdWord[`CW_ENABLE_OP];
  // don't-care bits are simply not looked at [R18]
  always_comb begin
    dec.shutdown = qs & ev & ~so; // [R3]
    dec.switchOn = qs & ev & so & ~eo; // [R4]
    dec.enableOp = qs & ev & so & eo; // [R4]
    dec.disableVoltage = ~ev; // [R3]
    dec.faultResetEdge = cmdWord[`CW_FAULT_RESET] & ~prevFaultReset; // [R7]
  end
endmodule

// [hw/drive_power_state_machine.sv]
`timescale 1ns/1ns
`include "pds_defines.svh"
// Functional notes
// R1: one state, changed only by command word; code also steps on init, error, power loss
// R2: status word always shows current state; code updates it one clock after the state changes
// R3: command bits 0,1,2,3,7; shutdown, disable voltage
// R4: switch on, disable and enable operation
// R5: combined command auto-steps into operation enabled
// R6: quick stop ignored, no quick-stop state
// R7: bit 7 edge in fault resets to disabled
// R8: elsewhere bit 7 edge clears warning only
// R9: controller returns bit 7 to zero after
// R10: warning in status bit 7 until reset
// R11: not-ready during init, then switch-on disabled
// R12: ready permits power; switched on; servo on
// R13: parameter writes allowed except when not ready
// R14: error: fault reaction, then fault state
// R15: undervoltage select 0: main-power-off, shutdown stop
// R16: undervoltage select 1: fault reaction stop
// R17: status bits 0..6 encode the state
// R18: don't-care bits ignored, invalid codes ignored
module drive_power_state_machine
  import pds_pkg::*;
#(
  parameter logic [7:0] FAULT_REACT_LEN = `FAULT_REACT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic cmdWrite,
  input wire logic [15:0] cmdIndex,
  input wire logic [15:0] cmdData,
  input wire logic initDone,
  input wire logic internalError,
  input wire logic warningEvent,
  input wire logic mainPowerOk,
  input wire logic undervoltageSel,
  output logic [15:0] statusWord,
  output logic [15:0] commandWord,
  output power_drive_state_t powerDriveState,
  output logic mainPowerPermit,
  output logic servoReady,
  output logic servoOn,
  output logic paramWriteEnable,
  output logic errorsClear,
  output logic shutdownStop,
  output logic faultReactStop
);
  typedef struct packed {
    power_drive_state_t st;
    logic [15:0] cmd;
    logic prevReset;
    logic warn;
    logic autoEnable;
    logic [7:0] reactCnt;
    logic clrPulse;
    logic [15:0] status;
    logic [1:0] initSync;
    logic [1:0] powerSync;
    logic [1:0] errSync;
    logic [1:0] warnSync;
    logic [1:0] uvSync;
  } state_t;

  state_t s_q;
  state_t s_d;
  cmd_decode_t dec;
  logic initOk;
  logic powerOk;
  logic errIn;
  logic warnIn;
  logic uvSel;
  logic [6:0] code;

  // init, power, error, warning and undervoltage pins pass two flops before any logic reads them
  assign initOk = s_q.initSync[1];
  assign powerOk = s_q.powerSync[1];
  assign errIn = s_q.errSync[1];
  assign warnIn = s_q.warnSync[1];
  assign uvSel = s_q.uvSync[1];

  cmd_decoder i_cmd_decoder (
    .cmdWord(s_q.cmd),
    .prevFaultReset(s_q.prevReset),
    .dec(dec)
  );

  // state encoding of status bits 0..6
  always_comb begin
    code = 7'h00;
    case (s_q.st)
      ST_NOT_READY: code = 7'h00;
      ST_ON_DISABLED: code = 7'h60;
      ST_READY: code = 7'h21;
      ST_SWITCHED_ON: code = 7'h23;
      ST_OP_ENABLED: code = 7'h27;
      ST_FAULT_REACT: code = 7'h2F;
      ST_FAULT: code = 7'h28;
      ST_MAIN_OFF: code = 7'h60;
      default: code = 7'h00;
    endcase
  end

  // next state; a command is evaluated one cycle after it is written
  always_comb begin
    s_d = s_q;
    s_d.clrPulse = 1'b0;
    s_d.initSync = {s_q.initSync[0], initDone};
    s_d.powerSync = {s_q.powerSync[0], mainPowerOk};
    s_d.errSync = {s_q.errSync[0], internalError};
    s_d.warnSync = {s_q.warnSync[0], warningEvent};
    s_d.uvSync = {s_q.uvSync[0], undervoltageSel};
    // only the command word object is taken [R1]
    if (cmdWrite && cmdIndex == `IDX_COMMAND_WORD && s_q.st != ST_NOT_READY) begin
      s_d.cmd = cmdData; // [R13]
    end
    s_d.prevReset = s_q.cmd[`CW_FAULT_RESET];
    // warning sticks; new event wins over the clear [R10]
    if (dec.faultResetEdge && s_q.st != ST_FAULT) begin
      s_d.warn = 1'b0; // [R8]
    end
    if (warnIn) begin
      s_d.warn = 1'b1; // [R10]
    end
    case (s_q.st)
      ST_NOT_READY: begin
        if (initOk) begin
          s_d.st = ST_ON_DISABLED; // [R11]
        end
      end
      ST_ON_DISABLED: begin
        if (dec.shutdown) begin
          s_d.st = ST_READY; // [R3]
        end
      end
      ST_READY: begin
        if (dec.disableVoltage) begin
          s_d.st = ST_ON_DISABLED;
        end else if ((dec.switchOn || dec.enableOp) && powerOk) begin
          s_d.st = ST_SWITCHED_ON; // [R4] [R12]
          s_d.autoEnable = dec.enableOp; // [R5]
        end
      end
      ST_SWITCHED_ON: begin
        s_d.autoEnable = 1'b0;
        if (dec.disableVoltage) begin
          s_d.st = ST_ON_DISABLED;
        end else if (dec.shutdown) begin
          s_d.st = ST_READY;
        end else if (dec.enableOp || s_q.autoEnable) begin
          s_d.st = ST_OP_ENABLED; // [R5]
        end
      end
      ST_OP_ENABLED: begin
        if (!powerOk && !uvSel) begin
          s_d.st = ST_MAIN_OFF; // [R15]
        end else if (!powerOk && uvSel) begin
          s_d.st = ST_FAULT_REACT; // [R16]
          s_d.reactCnt = 8'h00;
        end else if (dec.disableVoltage) begin
          s_d.st = ST_ON_DISABLED;
        end else if (dec.shutdown) begin
          s_d.st = ST_READY;
        end else if (dec.switchOn) begin
          s_d.st = ST_SWITCHED_ON; // [R4]
        end
        // quick stop (bit 2 low, bit 1 high) falls through untouched [R6]
      end
      ST_MAIN_OFF: begin
        if (dec.disableVoltage) begin
          s_d.st = ST_ON_DISABLED;
        end else if (dec.shutdown) begin
          s_d.st = ST_READY;
        end
      end
      ST_FAULT_REACT: begin
        s_d.reactCnt = s_q.reactCnt + 8'h01;
        if (s_q.reactCnt == FAULT_REACT_LEN - 8'h01) begin
          s_d.st = ST_FAULT; // [R14]
        end
      end
      ST_FAULT: begin
        if (dec.faultResetEdge && !errIn) begin
          s_d.st = ST_ON_DISABLED; // [R7]
          s_d.clrPulse = 1'b1;
          s_d.warn = warnIn;
        end
      end
      default: s_d.st = ST_NOT_READY;
    endcase
    // internal error overrides any operating state [R14]
    if (errIn && s_q.st != ST_NOT_READY && s_q.st != ST_FAULT_REACT
        && s_q.st != ST_FAULT) begin
      s_d.st = ST_FAULT_REACT;
      s_d.reactCnt = 8'h00;
    end
    s_d.status = {8'h00, s_q.warn, code}; // [R2] [R17]
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
      s_q.st <= ST_NOT_READY; // [R11]
      s_q.cmd <= `CMD_WORD_RESET;
      s_q.status <= `STAT_WORD_RESET;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  assign statusWord = s_q.status;
  assign commandWord = s_q.cmd;
  assign powerDriveState = s_q.st;
  assign mainPowerPermit = (s_q.st == ST_READY); // [R12]
  assign servoReady = (s_q.st == ST_SWITCHED_ON) || (s_q.st == ST_OP_ENABLED);
  assign servoOn = (s_q.st == ST_OP_ENABLED); // [R12]
  assign paramWriteEnable = (s_q.st != ST_NOT_READY); // [R13]
  assign errorsClear = s_q.clrPulse;
  assign shutdownStop = (s_q.st == ST_MAIN_OFF); // [R15]
  assign faultReactStop = (s_q.st == ST_FAULT_REACT); // [R16]

  property p_init;
    @(posedge clk_sys) disable iff (srst)
      s_q.st == ST_NOT_READY && clkEn && initOk |=> s_q.st == ST_ON_DISABLED;
  endproperty
  a_init: assert property (p_init) else $error("init not left"); // [R11]

  property p_status;
    @(posedge clk_sys) disable iff (srst)
      clkEn |=> statusWord[6:0] == $past(code);
  endproperty
  a_status: assert property (p_status) else $error("status code wrong"); // [R17]

  property p_react;
    @(posedge clk_sys) disable iff (srst)
      s_q.st == ST_OP_ENABLED && clkEn && !errIn && !powerOk && uvSel
      |=> s_q.st == ST_FAULT_REACT;
  endproperty
  a_react: assert property (p_react) else $error("uv select 1 missed"); // [R16]

  property p_mainoff;
    @(posedge clk_sys) disable iff (srst)
      s_q.st == ST_OP_ENABLED && clkEn && !errIn && !powerOk && !uvSel
      |=> s_q.st == ST_MAIN_OFF;
  endproperty
  a_mainoff: assert property (p_mainoff) else $error("uv select 0 missed"); // [R15]

  property p_reset;
    @(posedge clk_sys) disable iff (srst)
      s_q.st == ST_FAULT && clkEn && dec.faultResetEdge && !errIn
      |=> s_q.st == ST_ON_DISABLED && errorsClear;
  endproperty
  a_reset: assert property (p_reset) else $error("fault reset failed"); // [R7]

  property p_warn;
    @(posedge clk_sys) disable iff (srst)
      (clkEn && warnIn) ##1 clkEn |=> statusWord[`SW_WARNING];
  endproperty
  a_warn: assert property (p_warn) else $error("warning lost"); // [R10]

  property p_auto;
    @(posedge clk_sys) disable iff (srst)
      s_q.st == ST_SWITCHED_ON && s_q.autoEnable && clkEn && !errIn
      && !dec.disableVoltage && !dec.shutdown |=> s_q.st == ST_OP_ENABLED;
  endproperty
  a_auto: assert property (p_auto) else $error("auto enable missed"); // [R5]

  property p_quick;
    @(posedge clk_sys) disable iff (srst)
      s_q.st == ST_OP_ENABLED && clkEn && powerOk && !errIn
      && !s_q.cmd[`CW_QUICK_STOP] && s_q.cmd[`CW_ENABLE_VOLTAGE]
      |=> s_q.st == ST_OP_ENABLED;
  endproperty
  a_quick: assert property (p_quick) else $error("quick stop acted"); // [R6]

  property p_param;
    @(posedge clk_sys) disable iff (srst)
      s_q.st == ST_NOT_READY |-> !paramWriteEnable;
  endproperty
  a_param: assert property (p_param) else $error("params open in init"); // [R13]

  // a write outside the accepted window must leave the latched word alone
  property p_refuse;
    @(posedge clk_sys) disable iff (srst)
      clkEn && (s_q.st == ST_NOT_READY || !cmdWrite || cmdIndex != `IDX_COMMAND_WORD)
      |=> $stable(commandWord);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused write latched"); // [R13]

  property p_override;
    @(posedge clk_sys) disable iff (srst)
      clkEn && errIn && s_q.st != ST_NOT_READY && s_q.st != ST_FAULT_REACT
      && s_q.st != ST_FAULT |=> s_q.st == ST_FAULT_REACT;
  endproperty
  a_override: assert property (p_override) else $error("error not reacted"); // [R14]

  property p_pulse;
    @(posedge clk_sys) disable iff (srst)
      errorsClear && clkEn |=> !errorsClear;
  endproperty
  a_pulse: assert property (p_pulse) else $error("clear pulse too long"); // [R7]

  // a frozen block must not drift, or a stalled host would see phantom moves
  property p_freeze;
    @(posedge clk_sys) disable iff (srst)
      !clkEn |=> $stable(powerDriveState) && $stable(statusWord) && $stable(commandWord);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // [R1]
endmodule

// [hw/pds_defines.svh]
`ifndef PDS_DEFINES_SVH
`define PDS_DEFINES_SVH

// control word bit positions
`define CW_SWITCH_ON 0
`define CW_ENABLE_VOLTAGE 1
`define CW_QUICK_STOP 2
`define CW_ENABLE_OP 3
`define CW_FAULT_RESET 7
// status word bit positions
`define SW_READY 0
`define SW_SWITCHED_ON 1
`define SW_OP_ENABLED 2
`define SW_FAULT 3
`define SW_VOLTAGE 4
`define SW_QUICK_STOP 5
`define SW_ON_DISABLED 6
`define SW_WARNING 7
// object indices
`define IDX_COMMAND_WORD 16'h6040
`define IDX_STATUS_WORD 16'h6041
// reset values
`define CMD_WORD_RESET 16'h0000
`define STAT_WORD_RESET 16'h0000
// fault reaction settle time in cycles
`define FAULT_REACT_CYCLES 8'h10

`endif

// [hw/pds_pkg.sv]
package pds_pkg;
  // gray-coded along power-up to operation enabled
  typedef enum logic [2:0] {
    ST_NOT_READY = 3'h0,
    ST_ON_DISABLED = 3'h1,
    ST_READY = 3'h3,
    ST_SWITCHED_ON = 3'h2,
    ST_OP_ENABLED = 3'h6,
    ST_FAULT_REACT = 3'h7,
    ST_FAULT = 3'h5,
    ST_MAIN_OFF = 3'h4
  } power_drive_state_t;

  typedef struct packed {
    logic shutdown;
    logic switchOn;
    logic enableOp;
    logic disableVoltage;
    logic faultResetEdge;
  } cmd_decode_t;
endpackage

// [verif/ctrl_model.sv]
`timescale 1ns/1ns
// stands in for the motion controller that writes control word objects
module ctrl_model (
  input wire logic clk_sys,
  output logic cmdWrite,
  output logic [15:0] cmdIndex,
  output logic [15:0] cmdData
);
  initial begin
    cmdWrite = 1'b0;
    cmdIndex = 16'h0000;
    cmdData = 16'h0000;
  end

  // one-cycle strobe launched just after an edge
  task automatic send(input logic [15:0] idx, input logic [15:0] data);
    @(posedge clk_sys);
    #1 cmdWrite = 1'b1;
    cmdIndex = idx;
    cmdData = data;
    @(posedge clk_sys);
    #1 cmdWrite = 1'b0;
    cmdIndex = ~idx; // idle bus must not echo the last word
    cmdData = ~data;
    // reset bit goes low again before any further command
    if (data[7]) begin
      send(idx, data & 16'hFF7F);
    end
  endtask
endmodule

// [verif/drive_power_state_machine_test.sv]
`timescale 1ns/1ns
module drive_power_state_machine_test;
  import pds_pkg::*;
  logic clk_sys, srst, initDone, internalError, warningEvent, mainPowerOk, undervoltageSel;
  logic cmdWrite;
  logic clkEn;
  logic [15:0] cmdIndex, cmdData, statusWord, commandWord;
  power_drive_state_t powerDriveState;
  logic mainPowerPermit, servoReady, servoOn, paramWriteEnable, errorsClear;
  logic shutdownStop, faultReactStop;
  int nErrors = 0;
  int checks = 0;
  int nClears = 0;

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // count clear pulses so a missing or doubled pulse shows
  always @(posedge clk_sys) begin
    if (errorsClear === 1'b1) nClears++;
  end

  ctrl_model i_ctrl_model (.clk_sys(clk_sys), .cmdWrite(cmdWrite), .cmdIndex(cmdIndex),
    .cmdData(cmdData));

  // short fault reaction keeps the run brief
  drive_power_state_machine #(.FAULT_REACT_LEN(8'h04)) i_drive_power_state_machine (
    .clk_sys(clk_sys), .srst(srst), .clkEn(clkEn), .cmdWrite(cmdWrite), .cmdIndex(cmdIndex),
    .cmdData(cmdData), .initDone(initDone), .internalError(internalError),
    .warningEvent(warningEvent), .mainPowerOk(mainPowerOk), .undervoltageSel(undervoltageSel),
    .statusWord(statusWord), .commandWord(commandWord), .powerDriveState(powerDriveState),
    .mainPowerPermit(mainPowerPermit), .servoReady(servoReady), .servoOn(servoOn),
    .paramWriteEnable(paramWriteEnable), .errorsClear(errorsClear),
    .shutdownStop(shutdownStop), .faultReactStop(faultReactStop));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("errors %0d checks %0d", nErrors, checks);
    if (nErrors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic cmd(input logic [15:0] data);
    i_ctrl_model.send(16'h6040, data);
  endtask

  // bounded wait; a stuck state ends the run
  task automatic wait_state(input power_drive_state_t s);
    for (int i = 0; i < 60 && powerDriveState !== s; i++) cycles(1);
    if (powerDriveState !== s) begin
      check(16'(powerDriveState), 16'(s), "state wait timed out");
      complete_run();
    end
  endtask

  // status word lags the state by one edge
  task automatic expect_state(input power_drive_state_t s, input logic [15:0] sw);
    wait_state(s);
    cycles(1);
    check(statusWord, sw, "status word");
  endtask

  task automatic sc_init;
    cmd(16'h0006);
    cycles(4);
    check(16'(powerDriveState), 16'(ST_NOT_READY), "write taken in init");
    check({15'h0, paramWriteEnable}, 16'h0000, "params open in init");
    check(commandWord, 16'h0000, "write latched in init");
    initDone = 1'b1;
    expect_state(ST_ON_DISABLED, 16'h0060);
    check({15'h0, paramWriteEnable}, 16'h0001, "params closed");
  endtask

  // a write while the enable is low is lost, not held over
  task automatic sc_freeze;
    clkEn = 1'b0;
    cmd(16'h0006);
    cycles(4);
    check(commandWord, 16'h0000, "write taken while frozen");
    check(16'(powerDriveState), 16'(ST_ON_DISABLED), "state moved while frozen");
    clkEn = 1'b1;
    cycles(2);
    check(commandWord, 16'h0000, "lost write replayed");
    check(16'(powerDriveState), 16'(ST_ON_DISABLED), "state moved after thaw");
  endtask

  task automatic sc_basic;
    cmd(16'h0076); // mode bits set as noise
    expect_state(ST_READY, 16'h0021);
    check(commandWord, 16'h0076, "command not latched");
    check({15'h0, mainPowerPermit}, 16'h0001, "power permit");
    cmd(16'h0002);
    cycles(4);
    check(16'(powerDriveState), 16'(ST_READY), "quick stop acted");
    i_ctrl_model.send(16'h6041, 16'h0007);
    cycles(4);
    check(16'(powerDriveState), 16'(ST_READY), "foreign index taken");
    check(commandWord, 16'h0002, "foreign word latched");
    cmd(16'h0007);
    expect_state(ST_SWITCHED_ON, 16'h0023);
    check({14'h0, servoReady, servoOn}, 16'h0002, "servo ready only");
    cmd(16'h000F);
    expect_state(ST_OP_ENABLED, 16'h0027);
    check({14'h0, servoReady, servoOn}, 16'h0003, "servo on");
    cmd(16'h000B);
    cycles(4);
    check(16'(powerDriveState), 16'(ST_OP_ENABLED), "quick stop acted in op");
    cmd(16'h0007);
    expect_state(ST_SWITCHED_ON, 16'h0023);
    cmd(16'h0000);
    expect_state(ST_ON_DISABLED, 16'h0060);
  endtask

  task automatic sc_warning;
    warningEvent = 1'b1;
    cycles(2);
    warningEvent = 1'b0;
    cycles(12);
    check(statusWord, 16'h00E0, "warning held");
    cmd(16'h0080);
    cycles(4);
    check(statusWord, 16'h0060, "warning not cleared");
  endtask

  task automatic sc_error;
    int n0;
    internalError = 1'b1;
    expect_state(ST_FAULT_REACT, 16'h002F);
    expect_state(ST_FAULT, 16'h0028);
    n0 = nClears;
    cmd(16'h0080);
    cycles(4);
    check(16'(powerDriveState), 16'(ST_FAULT), "reset with error present");
    internalError = 1'b0;
    cycles(4);
    cmd(16'h0080);
    expect_state(ST_ON_DISABLED, 16'h0060);
    check(16'(nClears - n0), 16'h0001, "clear pulses");
  endtask

  task automatic sc_combined;
    cmd(16'h0006);
    wait_state(ST_READY);
    cmd(16'h000F);
    wait_state(ST_SWITCHED_ON);
    cycles(1);
    check(16'(powerDriveState), 16'(ST_OP_ENABLED), "no auto step");
  endtask

  task automatic sc_uv_fault;
    sc_combined();
    undervoltageSel = 1'b1;
    cycles(3);
    mainPowerOk = 1'b0;
    wait_state(ST_FAULT_REACT);
    check({15'h0, faultReactStop}, 16'h0001, "fault stop");
    expect_state(ST_FAULT, 16'h0028);
    mainPowerOk = 1'b1;
    cycles(4);
    cmd(16'h0080);
    expect_state(ST_ON_DISABLED, 16'h0060);
  endtask

  task automatic sc_uv_off;
    sc_combined();
    undervoltageSel = 1'b0;
    cycles(3);
    mainPowerOk = 1'b0;
    expect_state(ST_MAIN_OFF, 16'h0060);
    check({15'h0, shutdownStop}, 16'h0001, "shutdown stop");
  endtask

  initial begin
    srst = 1'b1;
    clkEn = 1'b1;
    initDone = 1'b0;
    internalError = 1'b0;
    warningEvent = 1'b0;
    mainPowerOk = 1'b1;
    undervoltageSel = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 srst = 1'b0;
    sc_init();
    sc_freeze();
    sc_basic();
    sc_warning();
    sc_error();
    sc_uv_fault();
    sc_uv_off();
    complete_run();
  end
endmodule
